// ===== rsa_alu.sv
`timescale 1ns/1ps
module rsa_alu
  import rsa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        instrValid,
  input  wire rsa_op_t     op,
  input  wire logic [7:0]  memData,
  input  wire logic [7:0]  immData,
  input  wire logic [2:0]  bitSel,
  output logic      [7:0]  accOut,
  output logic             carryFlag,
  output logic             halfCarryFlag,
  output logic             zeroFlag,
  output logic             signWrapFlag,
  output logic             signedCompareFlag,
  output logic             chainedZeroFlag,
  output logic             memWe,
  output logic      [7:0]  memWrData,
  output logic             skipPending,
  output logic             nullify,
  output logic             nullified
);

  // Complete datapath state kept in one register
  typedef struct packed {
    logic [7:0] acc;        // Accumulator
    logic       c;          // Carry
    logic       ac;         // Half carry
    logic       z;          // Zero
    logic       ov;         // Signed overflow
    logic       sc;         // Signed compare
    logic       cz;         // Chained zero
    logic       memWe;      // Memory write strobe, one cycle
    logic [7:0] memWd;      // Memory write data
    logic       skipNext;   // Next issued instruction is to be dropped
    logic       nullified;  // Last slot was a dropped instruction
  } rsa_state_t;

  rsa_state_t s;       // Current state
  rsa_state_t next_s;  // Next state

  logic [7:0] subB;      // Subtrahend: memory byte or immediate
  logic       subBorrow; // Subtract uses the carry flag
  logic [7:0] subDiff;   // Subtractor outputs
  logic       subC;
  logic       subAc;
  logic       subOv;
  logic       issue;     // An instruction really executes this cycle

  // One-hot mask of the selected bit; used by the bit test and the bit set
  function automatic logic [7:0] bitMask(input logic [2:0] sel);
    bitMask = BYTE_ONE << sel;
  endfunction

  // Writes flags common to every subtract form
  function automatic rsa_state_t subFlags(input rsa_state_t st, input logic [7:0] d,
                                          input logic c, input logic ac, input logic ov,
                                          input logic chained);
    rsa_state_t r;
    r     = st;
    r.c   = c;
    r.ac  = ac;
    r.ov  = ov;
    r.z   = (d == BYTE_ZERO);
    r.sc  = ov ^ d[7];
    // Borrow forms keep zero across a multi-byte chain
    r.cz  = chained ? (r.z & st.cz) : r.z;
    subFlags = r;
  endfunction

  // Immediate forms take the instruction's constant, the rest the memory byte
  always_comb begin
    subB      = (op == OP_SUB_BORROW_IMM || op == OP_MINUS_IMM) ? immData : memData;
    subBorrow = (op == OP_SUB_BORROW || op == OP_SUB_BORROW_IMM || op == OP_SUB_BORROW_TO_MEM);
  end

  rsa_subtractor #(
    .W          (DATA_W)
  ) u_rsa_subtractor (
    .minuend    (s.acc),
    .subtrahend (subB),
    .useBorrow  (subBorrow),
    .carryIn    (s.c),
    .diff       (subDiff),
    .carryOut   (subC),
    .halfCarry  (subAc),
    .signWrap   (subOv)
  );

  // A slot arriving behind a taken skip is swallowed, not executed
  assign issue   = instrValid && !s.skipNext;
  assign nullify = instrValid && s.skipNext;

  // Next-state logic: one instruction per valid slot
  always_comb begin
    next_s           = s;
    next_s.memWe     = 1'b0;
    next_s.nullified = 1'b0;
    if (nullify) begin
      // Dropped slot: no write, no flag, only the skip is consumed
      next_s.skipNext  = 1'b0;
      next_s.nullified = 1'b1;
    end else if (issue) begin
      unique case (op)
        OP_NOP: begin
        end
        OP_ROT_LEFT_IN_PLACE: begin
          next_s.memWe = 1'b1;
          next_s.memWd = {memData[6:0], memData[7]};
        end
        OP_ROT_LEFT_TO_ACC: begin
          next_s.acc = {memData[6:0], memData[7]};
        end
        OP_ROT_LEFT_THRU_CARRY: begin
          next_s.memWe = 1'b1;
          next_s.memWd = {memData[6:0], s.c};
          next_s.c     = memData[7];
        end
        OP_ROT_LEFT_THRU_CARRY_TO_ACC: begin
          next_s.acc = {memData[6:0], s.c};
          next_s.c   = memData[7];
        end
        OP_ROT_RIGHT_IN_PLACE: begin
          next_s.memWe = 1'b1;
          next_s.memWd = {memData[0], memData[7:1]};
        end
        OP_ROT_RIGHT_TO_ACC: begin
          next_s.acc = {memData[0], memData[7:1]};
        end
        OP_ROT_RIGHT_THRU_CARRY: begin
          next_s.memWe = 1'b1;
          next_s.memWd = {s.c, memData[7:1]};
          next_s.c     = memData[0];
        end
        OP_ROT_RIGHT_THRU_CARRY_TO_ACC: begin
          next_s.acc = {s.c, memData[7:1]};
          next_s.c   = memData[0];
        end
        OP_SUB_BORROW, OP_SUB_BORROW_IMM: begin
          next_s     = subFlags(s, subDiff, subC, subAc, subOv, 1'b1);
          next_s.acc = subDiff;
        end
        OP_SUB_BORROW_TO_MEM: begin
          next_s       = subFlags(s, subDiff, subC, subAc, subOv, 1'b1);
          next_s.memWe = 1'b1;
          next_s.memWd = subDiff;
        end
        OP_MINUS, OP_MINUS_IMM: begin
          next_s     = subFlags(s, subDiff, subC, subAc, subOv, 1'b0);
          next_s.acc = subDiff;
        end
        OP_MINUS_TO_MEM: begin
          next_s       = subFlags(s, subDiff, subC, subAc, subOv, 1'b0);
          next_s.memWe = 1'b1;
          next_s.memWd = subDiff;
        end
        OP_DEC_SKIP_ZERO: begin
          next_s.memWe    = 1'b1;
          next_s.memWd    = memData - BYTE_ONE;
          next_s.skipNext = (memData == BYTE_ONE);
        end
        OP_DEC_SKIP_ZERO_TO_ACC: begin
          next_s.acc      = memData - BYTE_ONE;
          next_s.skipNext = (memData == BYTE_ONE);
        end
        OP_INC_SKIP_ZERO: begin
          next_s.memWe    = 1'b1;
          next_s.memWd    = memData + BYTE_ONE;
          next_s.skipNext = (memData == BYTE_ALL);
        end
        OP_INC_SKIP_ZERO_TO_ACC: begin
          next_s.acc      = memData + BYTE_ONE;
          next_s.skipNext = (memData == BYTE_ALL);
        end
        OP_SKIP_BIT_NONZERO: begin
          next_s.skipNext = |(memData & bitMask(bitSel));
        end
        OP_SKIP_NONZERO: begin
          // Read and rewritten unchanged, so side effects of a write still occur
          next_s.memWe    = 1'b1;
          next_s.memWd    = memData;
          next_s.skipNext = (memData != BYTE_ZERO);
        end
        OP_SET_BYTE: begin
          next_s.memWe = 1'b1;
          next_s.memWd = BYTE_ALL;
        end
        OP_SET_BIT: begin
          next_s.memWe = 1'b1;
          next_s.memWd = memData | bitMask(bitSel);
        end
        default: begin
          // Unused opcode codes act as no operation
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{acc: ACC_RST, c: FLAG_RST, ac: FLAG_RST, z: FLAG_RST, ov: FLAG_RST,
             sc: FLAG_RST, cz: FLAG_RST, memWe: 1'b0, memWd: ACC_RST,
             skipNext: 1'b0, nullified: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Registered outputs
  assign accOut            = s.acc;
  assign carryFlag         = s.c;
  assign halfCarryFlag     = s.ac;
  assign zeroFlag          = s.z;
  assign signWrapFlag      = s.ov;
  assign signedCompareFlag = s.sc;
  assign chainedZeroFlag   = s.cz;
  assign memWe             = s.memWe;
  assign memWrData         = s.memWd;
  assign skipPending       = s.skipNext;
  assign nullified         = s.nullified;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Helper: op really executed in this cycle
  sequence doOp(rsa_op_t o);
    instrValid && !skipPending && op == o;
  endsequence

  // Decrement that reaches zero, then the dropped slot
  sequence decHitsZero;
    doOp(OP_DEC_SKIP_ZERO) ##0 memData == BYTE_ONE;
  endsequence
  sequence droppedSlot;
    instrValid && nullify ##1 nullified && !memWe;
  endsequence

  rot_left_acc_a: assert property (doOp(OP_ROT_LEFT_TO_ACC) |=>
    accOut == {$past(memData[6:0]), $past(memData[7])} && !memWe && $stable(carryFlag))
    else $error("rotate left to acc wrong");

  rot_left_carry_a: assert property (doOp(OP_ROT_LEFT_THRU_CARRY) |=>
    memWe && memWrData == {$past(memData[6:0]), $past(carryFlag)} && carryFlag == $past(memData[7]))
    else $error("rotate left through carry wrong");

  rot_left_cacc_a: assert property (doOp(OP_ROT_LEFT_THRU_CARRY_TO_ACC) |=>
    !memWe && accOut == {$past(memData[6:0]), $past(carryFlag)} && carryFlag == $past(memData[7]))
    else $error("rotate left through carry to acc wrong");

  rot_right_mem_a: assert property (doOp(OP_ROT_RIGHT_IN_PLACE) |=>
    memWe && memWrData == {$past(memData[0]), $past(memData[7:1])} && $stable(zeroFlag) && $stable(carryFlag))
    else $error("rotate right in place wrong");

  rot_right_acc_a: assert property (doOp(OP_ROT_RIGHT_TO_ACC) |=>
    !memWe && accOut == {$past(memData[0]), $past(memData[7:1])})
    else $error("rotate right to acc wrong");

  rot_right_carry_a: assert property (doOp(OP_ROT_RIGHT_THRU_CARRY) |=>
    memWe && memWrData == {$past(carryFlag), $past(memData[7:1])} && carryFlag == $past(memData[0]))
    else $error("rotate right through carry wrong");

  rot_right_cacc_a: assert property (doOp(OP_ROT_RIGHT_THRU_CARRY_TO_ACC) |=>
    !memWe && accOut == {$past(carryFlag), $past(memData[7:1])} && carryFlag == $past(memData[0]))
    else $error("rotate right through carry to acc wrong");

  sub_borrow_a: assert property (doOp(OP_SUB_BORROW) |=>
    accOut == 8'($past(accOut) - $past(memData) - {7'b000_0000, !$past(carryFlag)}))
    else $error("subtract with borrow wrong");

  sub_borrow_imm_a: assert property (doOp(OP_SUB_BORROW_IMM) |=>
    accOut == 8'($past(accOut) - $past(immData) - {7'b000_0000, !$past(carryFlag)}))
    else $error("subtract immediate with borrow wrong");

  sub_borrow_mem_a: assert property (doOp(OP_SUB_BORROW_TO_MEM) |=>
    memWe && $stable(accOut) &&
    memWrData == 8'($past(accOut) - $past(memData) - {7'b000_0000, !$past(carryFlag)}))
    else $error("subtract with borrow to memory wrong");

  sub_carry_a: assert property (doOp(OP_MINUS) |=>
    carryFlag == ($past(accOut) >= $past(memData)))
    else $error("subtract carry wrong");

  sub_flags_a: assert property (doOp(OP_MINUS) |=>
    zeroFlag == (accOut == BYTE_ZERO) && chainedZeroFlag == zeroFlag && signedCompareFlag == (signWrapFlag ^ accOut[7]))
    else $error("subtract flags wrong");

  minus_mem_a: assert property (doOp(OP_MINUS_TO_MEM) |=>
    memWe && memWrData == 8'($past(accOut) - $past(memData)) && $stable(accOut))
    else $error("subtract to memory wrong");

  minus_imm_a: assert property (doOp(OP_MINUS_IMM) |=>
    accOut == 8'($past(accOut) - $past(immData)))
    else $error("subtract immediate wrong");

  dec_skip_a: assert property (decHitsZero |=> memWe && memWrData == BYTE_ZERO && skipPending)
    else $error("decrement skip wrong");

  inc_skip_acc_a: assert property (doOp(OP_INC_SKIP_ZERO_TO_ACC) |=>
    !memWe && accOut == 8'($past(memData) + BYTE_ONE) && skipPending == (accOut == BYTE_ZERO))
    else $error("increment skip to acc wrong");

  skip_bit_a: assert property (doOp(OP_SKIP_BIT_NONZERO) |=>
    skipPending == $past(memData[bitSel]) && !memWe)
    else $error("bit skip wrong");

  set_byte_a: assert property (doOp(OP_SET_BYTE) |=> memWe && memWrData == BYTE_ALL && $stable(carryFlag))
    else $error("set byte wrong");

  drop_slot_a: assert property (skipPending && instrValid |-> droppedSlot ##0
    $stable(accOut) && $stable(carryFlag) && !skipPending)
    else $error("skipped slot not dropped");

  two_cycle_a: assert property (decHitsZero ##1 instrValid |=> nullified)
    else $error("skip did not take a second cycle");

endmodule

// ===== rsa_pkg.sv
package rsa_pkg;

  // Data path width of the core
  localparam int DATA_W = 8;

  // Reset values of the datapath state
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic       FLAG_RST = 1'b0;

  // Constants used by the byte operations
  localparam logic [7:0] BYTE_ONE  = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ALL  = 8'hFF;

  // A skip costs one extra instruction slot (two cycles in total)
  localparam int SKIP_CYCLES = 2;

  // Operations handed over by the instruction decoder
  typedef enum logic [4:0] {
    OP_NOP,
    OP_ROT_LEFT_IN_PLACE,
    OP_ROT_LEFT_TO_ACC,
    OP_ROT_LEFT_THRU_CARRY,
    OP_ROT_LEFT_THRU_CARRY_TO_ACC,
    OP_ROT_RIGHT_IN_PLACE,
    OP_ROT_RIGHT_TO_ACC,
    OP_ROT_RIGHT_THRU_CARRY,
    OP_ROT_RIGHT_THRU_CARRY_TO_ACC,
    OP_SUB_BORROW,
    OP_SUB_BORROW_IMM,
    OP_SUB_BORROW_TO_MEM,
    OP_MINUS,
    OP_MINUS_TO_MEM,
    OP_MINUS_IMM,
    OP_DEC_SKIP_ZERO,
    OP_DEC_SKIP_ZERO_TO_ACC,
    OP_INC_SKIP_ZERO,
    OP_INC_SKIP_ZERO_TO_ACC,
    OP_SKIP_BIT_NONZERO,
    OP_SKIP_NONZERO,
    OP_SET_BYTE,
    OP_SET_BIT
  } rsa_op_t;

endpackage

// ===== rsa_subtractor.sv
`timescale 1ns/1ps
// Eight-bit subtractor with optional borrow input and carry, half carry and overflow outputs
module rsa_subtractor
  import rsa_pkg::*;
#(
  parameter int W = DATA_W
) (
  input  wire logic [W-1:0] minuend,
  input  wire logic [W-1:0] subtrahend,
  input  wire logic         useBorrow,
  input  wire logic         carryIn,
  output logic      [W-1:0] diff,
  output logic              carryOut,
  output logic              halfCarry,
  output logic              signWrap
);

  logic         addCarry;  // Carry into the adder: inverted borrow
  logic [4:0]   lowSum;    // Low nibble with its carry
  logic [W:0]   fullSum;   // Whole byte with its carry

  // Subtraction as addition of the complement; carry set means no borrow
  always_comb begin
    addCarry  = useBorrow ? carryIn : 1'b1;
    lowSum    = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'b0000, addCarry};
    fullSum   = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, addCarry};
    diff      = fullSum[W-1:0];
    carryOut  = fullSum[W];
    halfCarry = lowSum[4];
    // Overflow when operand signs differ and the result sign left the minuend's
    signWrap  = (minuend[W-1] ^ subtrahend[W-1]) & (diff[W-1] ^ minuend[W-1]);
  end

endmodule

// ===== tb_rotate_subtract_skip_alu.sv
`timescale 1ns/1ps
// Self-checking bench for the rotate, subtract and skip datapath
module tb_rotate_subtract_skip_alu
  import rsa_pkg::*;
;
  logic       clk;                 // Instruction clock
  logic       rst_n;               // Core reset
  logic       instrValid;          // Slot strobe
  rsa_op_t    op;                  // Slot operation
  logic [7:0] memData;             // Memory operand
  logic [7:0] immData;             // Immediate operand
  logic [2:0] bitSel;              // Bit index
  logic [7:0] accOut;
  logic       carryFlag, halfCarryFlag, zeroFlag, signWrapFlag, signedCompareFlag, chainedZeroFlag;
  logic       memWe;
  logic [7:0] memWrData;
  logic       skipPending, nullify, nullified;
  int         nErrors;             // Mismatch count
  int         testsRun;            // Comparison count
  logic [7:0] eAcc;                // Expected accumulator
  logic       eC, eH, eZ, eV, eS, eCz; // Expected flags

  rsa_alu u_rsa_alu (.clk(clk), .rst_n(rst_n), .instrValid(instrValid), .op(op), .memData(memData),
    .immData(immData), .bitSel(bitSel), .accOut(accOut), .carryFlag(carryFlag), .halfCarryFlag(halfCarryFlag),
    .zeroFlag(zeroFlag), .signWrapFlag(signWrapFlag), .signedCompareFlag(signedCompareFlag),
    .chainedZeroFlag(chainedZeroFlag), .memWe(memWe), .memWrData(memWrData), .skipPending(skipPending),
    .nullify(nullify), .nullified(nullified));

  // Free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare one value, four-state exact
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Accumulator, flags and write strobe against the expected state
  task automatic checkAll(input logic we, input logic [7:0] wd);
    chk(accOut, eAcc, "acc");
    chk({2'b00, carryFlag, halfCarryFlag, zeroFlag, signWrapFlag, signedCompareFlag, chainedZeroFlag},
        {2'b00, eC, eH, eZ, eV, eS, eCz}, "flags");
    chk({7'h00, memWe}, {7'h00, we}, "write strobe");
    if (we) begin
      chk(memWrData, wd, "write data");
    end
  endtask

  // Present slot inputs; the caller lets the taking edge pass
  task automatic put(input rsa_op_t o, input logic [7:0] m, input logic [7:0] x, input logic [2:0] b);
    instrValid = 1'b1;
    op = o;
    memData = m;
    immData = x;
    bitSel = b;
  endtask

  // One slot; results are settled just after the taking edge
  task automatic slot(input rsa_op_t o, input logic [7:0] m, input logic [7:0] x, input logic [2:0] b);
    put(o, m, x, b);
    @(posedge clk);
    #1;
  endtask

  // Reference rotation: {to accumulator, new carry, result}
  function automatic logic [9:0] rotf(input rsa_op_t o, input logic [7:0] m, input logic c);
    case (o)
      OP_ROT_LEFT_IN_PLACE:           rotf = {1'b0, c, m[6:0], m[7]};
      OP_ROT_LEFT_TO_ACC:             rotf = {1'b1, c, m[6:0], m[7]};
      OP_ROT_LEFT_THRU_CARRY:         rotf = {1'b0, m[7], m[6:0], c};
      OP_ROT_LEFT_THRU_CARRY_TO_ACC:  rotf = {1'b1, m[7], m[6:0], c};
      OP_ROT_RIGHT_IN_PLACE:          rotf = {1'b0, c, m[0], m[7:1]};
      OP_ROT_RIGHT_TO_ACC:            rotf = {1'b1, c, m[0], m[7:1]};
      OP_ROT_RIGHT_THRU_CARRY:        rotf = {1'b0, m[0], c, m[7:1]};
      default:                        rotf = {1'b1, m[0], c, m[7:1]};
    endcase
  endfunction

  // Reference subtract; updates all six expected flags
  task automatic subCalc(input logic [7:0] a, input logic [7:0] x, input logic useB, output logic [7:0] res);
    logic       bor;
    logic [8:0] d;
    logic [4:0] h;
    bor = useB & ~eC;
    d = {1'b0, a} - {1'b0, x} - {8'h00, bor};
    h = {1'b0, a[3:0]} - {1'b0, x[3:0]} - {4'h0, bor};
    res = d[7:0];
    eC = ~d[8];
    eH = ~h[4];
    eV = (a[7] ^ x[7]) & (res[7] ^ a[7]);
    eZ = (res == 8'h00);
    eS = eV ^ res[7];
    eCz = useB ? (eZ & eCz) : eZ;
  endtask

  // Load carry through a memory rotate, then acc through a rotate that keeps flags
  task automatic load(input logic [7:0] a, input logic c);
    slot(OP_ROT_LEFT_THRU_CARRY, {c, 7'h00}, 8'h00, 3'd0);
    slot(OP_ROT_RIGHT_TO_ACC, {a[6:0], a[7]}, 8'h00, 3'd0);
    eC = c;
    eAcc = a;
    checkAll(1'b0, 8'h00);
  endtask

  // All eight rotates, both carry values, back to back
  task automatic testRotate();
    logic [9:0] r;
    logic [7:0] m;
    rsa_op_t    o;
    for (int k = 0; k < 16; k++) begin
      o = rsa_op_t'(int'(OP_ROT_LEFT_IN_PLACE) + k / 2);
      m = k[0] ? 8'h69 : 8'h96;
      slot(OP_ROT_LEFT_THRU_CARRY, {k[0], 7'h00}, 8'h00, 3'd0);
      // Old carry lands in bit 0, the loaded bit 7 becomes the new carry
      r[7:0] = {7'h00, eC};
      eC = k[0];
      checkAll(1'b1, r[7:0]);
      slot(o, m, 8'h00, 3'd0);
      r = rotf(o, m, eC);
      eC = r[8];
      if (r[9]) begin
        eAcc = r[7:0];
      end
      checkAll(~r[9], r[7:0]);
    end
    $display("test rotate done");
  endtask

  // Every subtract form, including a chained zero sequence
  task automatic testSubtract();
    rsa_op_t    sOp[10] = '{OP_MINUS, OP_SUB_BORROW, OP_SUB_BORROW, OP_SUB_BORROW_IMM, OP_SUB_BORROW_TO_MEM,
                            OP_MINUS_TO_MEM, OP_MINUS_IMM, OP_SUB_BORROW, OP_SUB_BORROW_IMM, OP_SUB_BORROW};
    logic [7:0] sA[10] = '{8'h05, 8'h05, 8'h00, 8'h80, 8'h10, 8'h7F, 8'h33, 8'h44, 8'h09, 8'h21};
    logic [7:0] sX[10] = '{8'h07, 8'h07, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h33, 8'h43, 8'h01, 8'h20};
    logic       sC[10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic       useB, imm, toMem;
    logic [7:0] res;
    for (int k = 0; k < 10; k++) begin
      useB = sOp[k] inside {OP_SUB_BORROW, OP_SUB_BORROW_IMM, OP_SUB_BORROW_TO_MEM};
      imm = sOp[k] inside {OP_SUB_BORROW_IMM, OP_MINUS_IMM};
      toMem = sOp[k] inside {OP_SUB_BORROW_TO_MEM, OP_MINUS_TO_MEM};
      load(sA[k], sC[k]);
      // The unused operand port carries the complement to catch a wrong source
      slot(sOp[k], imm ? ~sX[k] : sX[k], imm ? sX[k] : ~sX[k], 3'd0);
      subCalc(sA[k], sX[k], useB, res);
      if (!toMem) begin
        eAcc = res;
      end
      checkAll(toMem, res);
    end
    $display("test subtract done");
  endtask

  // Skip forms, taken and not taken, each followed by a slot that writes memory and flags
  task automatic testSkip();
    rsa_op_t    kOp[12] = '{OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_TO_ACC, OP_DEC_SKIP_ZERO_TO_ACC,
                            OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_TO_ACC, OP_INC_SKIP_ZERO_TO_ACC,
                            OP_SKIP_BIT_NONZERO, OP_SKIP_BIT_NONZERO, OP_SKIP_NONZERO, OP_SKIP_NONZERO};
    logic [7:0] kM[12] = '{8'h01, 8'h00, 8'h01, 8'h02, 8'hFF, 8'hFE, 8'hFF, 8'h7F, 8'h08, 8'hF7, 8'h5A, 8'h00};
    logic [7:0] r;
    logic [7:0] res;
    logic       sk, we;
    for (int k = 0; k < 12; k++) begin
      case (kOp[k])
        OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_TO_ACC: r = kM[k] - 8'h01;
        OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_TO_ACC: r = kM[k] + 8'h01;
        default:                                   r = kM[k];
      endcase
      sk = (kOp[k] == OP_SKIP_BIT_NONZERO) ? kM[k][3] : ((kOp[k] == OP_SKIP_NONZERO) ? (r != 8'h00) : (r == 8'h00));
      we = kOp[k] inside {OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO, OP_SKIP_NONZERO};
      slot(kOp[k], kM[k], 8'h00, 3'd3);
      if (kOp[k] inside {OP_DEC_SKIP_ZERO_TO_ACC, OP_INC_SKIP_ZERO_TO_ACC}) begin
        eAcc = r;
      end
      checkAll(we, r);
      chk({7'h00, skipPending}, {7'h00, sk}, "skip pending");
      put(OP_MINUS_TO_MEM, 8'h01, 8'h00, 3'd0);
      #1;
      chk({7'h00, nullify}, {7'h00, sk}, "drop strobe");
      @(posedge clk);
      #1;
      res = 8'h00;
      if (!sk) begin
        subCalc(eAcc, 8'h01, 1'b0, res);
      end
      checkAll(~sk, res);
      chk({6'h00, nullified, skipPending}, {6'h00, sk, 1'b0}, "drop pulse");
    end
    $display("test skip done");
  endtask

  // Set whole byte and each single bit; acc and flags stay
  task automatic testSet();
    slot(OP_SET_BYTE, 8'h00, 8'h00, 3'd0);
    checkAll(1'b1, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      slot(OP_SET_BIT, 8'h00, 8'h00, i[2:0]);
      checkAll(1'b1, 8'h01 << i);
    end
    // A no-operation slot with busy operands must leave everything alone
    slot(OP_NOP, 8'hFF, 8'hFF, 3'd7);
    checkAll(1'b0, 8'h00);
    $display("test set done");
  endtask

  // Reset in mid-run while a skip is pending
  task automatic testMidReset();
    slot(OP_DEC_SKIP_ZERO_TO_ACC, 8'h01, 8'h00, 3'd0);
    instrValid = 1'b0;
    rst_n = 1'b0;
    #1;
    {eAcc, eC, eH, eZ, eV, eS, eCz} = '0;
    checkAll(1'b0, 8'h00);
    chk({5'h00, skipPending, nullified, nullify}, 8'h00, "reset skip state");
    chk(memWrData, 8'h00, "reset write data");
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    slot(OP_MINUS_IMM, 8'h00, 8'h00, 3'd0);
    subCalc(8'h00, 8'h00, 1'b0, eAcc);
    checkAll(1'b0, 8'h00);
    $display("test mid reset done");
  endtask

  // Verdict and end of run
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the roughly one hundred cycles the tests need
  initial begin
    #50000;
    nErrors++;
    stopTest();
  end

  // Main sequence
  initial begin
    nErrors = 0;
    testsRun = 0;
    rst_n = 1'b0;
    instrValid = 1'b0;
    op = OP_NOP;
    memData = 8'h00;
    immData = 8'h00;
    bitSel = 3'd0;
    {eAcc, eC, eH, eZ, eV, eS, eCz} = '0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    checkAll(1'b0, 8'h00);
    chk({6'h00, skipPending, nullified}, 8'h00, "reset state");
    $display("test reset done");
    testRotate();
    testSubtract();
    testSkip();
    testSet();
    testMidReset();
    stopTest();
  end
endmodule
